// ==== rtl/rss_exec.v ====
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rss_consts.vh"

// Overview of operation
// - Left rotate through carry into accumulator; carry takes operand bit 7.
// - Right rotate memory byte, bit 0 to bit 7, no flag change.
// - Right rotate into accumulator only; memory and flags untouched.
// - Right rotate memory through carry; old carry to bit 7, carry from bit 0.
// - Same nine-bit right rotation, result to accumulator, carry updated.
// - Accumulator minus memory minus inverted carry into accumulator; six flags.
// - Immediate subtract with borrow into accumulator; same six flags.
// - Subtract with borrow, result written back to memory; same flags.
// - Plain subtract ignoring carry input into accumulator; six flags updated.
// - Decrement memory, write back, skip next when zero, no flags.
// - Decrement into accumulator, memory unchanged, skip when zero.
// - Increment memory, write back, skip next when wrapped result zero.
// - Increment into accumulator, memory unchanged, skip when zero.
// - A skip replaces the next instruction with one dummy cycle.
// - Set byte writes all ones to memory, flags unchanged.
// - Set bit forces selected bit to one, others and flags unchanged.
// - Skip next when selected memory bit is one, no flag change.
// - Read memory byte, write it back, skip when byte nonzero.
module rss_exec
(
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // Decoder request
  input  wire        exec_valid,
  input  wire [4:0]  exec_op,
  input  wire [2:0]  exec_bit,
  input  wire [7:0]  exec_operand,
  input  wire [7:0]  exec_addr,
  // Data memory write and sequencer
  output reg         mem_we_q,
  output reg  [7:0]  mem_addr_q,
  output reg  [7:0]  mem_wdata_q,
  output reg         skip_q,
  output reg         dummy_q,
  output reg         done_q,
  // Core state
  output reg  [7:0]  acc_q,
  output reg  [5:0]  flags_q
);

  // --------------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------------
  reg                   wr_pend_q;
  reg                   rd_pend_q;
  reg  [4:0]            bus_addr_q;
  reg  [7:0]            opnd_reg_q;
  reg  [4:0]            cmd_op_q;
  reg  [2:0]            cmd_bit_q;
  reg                   cmd_pend_q;
  reg                   last_skip_q;
  reg  [31:0]           rd_mux;
  wire                  addr_ok;
  wire                  sw_cmd_wr;

  // Only nonsequential transfers are decoded, those outside the map to the empty slot; hsize is ignored and the low two address bits are dropped
  assign addr_ok   = (haddr[31:`RSS_ADDR_W] == 27'h000_0000);
  assign sw_cmd_wr = wr_pend_q & (bus_addr_q == `RSS_REG_CMD);

  // --------------------------------------------------------------------------
  // Request selection
  // --------------------------------------------------------------------------
  reg                   go;
  reg  [4:0]            op;
  reg  [2:0]            bsel;
  reg  [7:0]            opnd;
  reg  [7:0]            maddr;

  // Decoder wins; a software command waits until the decoder is quiet.
  // Anything arriving in the dummy cycle is the squashed instruction.
  always @*
  begin
    go    = 1'b0;
    op    = exec_op;
    bsel  = exec_bit;
    opnd  = exec_operand;
    maddr = exec_addr;
    if (!dummy_q)
    begin
      if (exec_valid)
        go = 1'b1;
      else if (cmd_pend_q)
      begin
        go    = 1'b1;
        op    = cmd_op_q;
        bsel  = cmd_bit_q;
        opnd  = opnd_reg_q;
        maddr = `RSS_BYTE_ZERO;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Subtractor shared by the four subtract forms
  // --------------------------------------------------------------------------
  wire                  is_sub;
  wire                  bin;
  wire [8:0]            diff;
  wire [4:0]            lo_diff;
  wire [7:0]            sres;
  wire                  s_ov;

  assign is_sub  = (op == `RSS_OP_SUB);
  // Plain subtract takes no borrow from carry
  assign bin     = is_sub ? 1'b0 : ~flags_q[`RSS_F_C];
  assign diff    = {1'b0, acc_q} - {1'b0, opnd} - {8'h00, bin};
  assign lo_diff = {1'b0, acc_q[3:0]} - {1'b0, opnd[3:0]} - {`RSS_NIB_ZERO, bin};
  assign sres    = diff[7:0];
  assign s_ov    = (acc_q[7] ^ opnd[7]) & (acc_q[7] ^ sres[7]);

  // --------------------------------------------------------------------------
  // Operation decode
  // --------------------------------------------------------------------------
  reg  [7:0]            res;
  reg                   wr_mem;
  reg                   wr_acc;
  reg                   skip;
  reg  [5:0]            flg;
  reg                   sub_flags;
  wire [7:0]            dec_v;
  wire [7:0]            inc_v;
  wire [7:0]            bit_mask;

  assign dec_v    = opnd - `RSS_BYTE_ONE;
  assign inc_v    = opnd + `RSS_BYTE_ONE;
  assign bit_mask = `RSS_BYTE_ONE << bsel;

  always @*
  begin
    res       = opnd;
    wr_mem    = 1'b0;
    wr_acc    = 1'b0;
    skip      = 1'b0;
    flg       = flags_q;
    sub_flags = 1'b0;
    case (op)
      `RSS_OP_ROTL_C_ACC:
      begin
        res              = {opnd[6:0], flags_q[`RSS_F_C]};
        wr_acc           = 1'b1;
        flg[`RSS_F_C]    = opnd[7];
      end
      `RSS_OP_ROTR:
      begin
        res    = {opnd[0], opnd[7:1]};
        wr_mem = 1'b1;
      end
      `RSS_OP_ROTR_ACC:
      begin
        res    = {opnd[0], opnd[7:1]};
        wr_acc = 1'b1;
      end
      `RSS_OP_ROTR_C:
      begin
        res           = {flags_q[`RSS_F_C], opnd[7:1]};
        wr_mem        = 1'b1;
        flg[`RSS_F_C] = opnd[0];
      end
      `RSS_OP_ROTR_C_ACC:
      begin
        res           = {flags_q[`RSS_F_C], opnd[7:1]};
        wr_acc        = 1'b1;
        flg[`RSS_F_C] = opnd[0];
      end
      `RSS_OP_SUBB, `RSS_OP_SUBB_IMM, `RSS_OP_SUB:
      begin
        res       = sres;
        wr_acc    = 1'b1;
        sub_flags = 1'b1;
      end
      `RSS_OP_SUBB_MEM:
      begin
        res       = sres;
        wr_mem    = 1'b1;
        sub_flags = 1'b1;
      end
      `RSS_OP_DEC_SKIP:
      begin
        res    = dec_v;
        wr_mem = 1'b1;
        skip   = (dec_v == `RSS_BYTE_ZERO);
      end
      `RSS_OP_DEC_ACC_SKIP:
      begin
        res    = dec_v;
        wr_acc = 1'b1;
        skip   = (dec_v == `RSS_BYTE_ZERO);
      end
      `RSS_OP_INC_SKIP:
      begin
        res    = inc_v;
        wr_mem = 1'b1;
        skip   = (inc_v == `RSS_BYTE_ZERO);
      end
      `RSS_OP_INC_ACC_SKIP:
      begin
        res    = inc_v;
        wr_acc = 1'b1;
        skip   = (inc_v == `RSS_BYTE_ZERO);
      end
      `RSS_OP_SET:
      begin
        res    = `RSS_BYTE_ALL;
        wr_mem = 1'b1;
      end
      `RSS_OP_SET_BIT:
      begin
        res    = opnd | bit_mask;
        wr_mem = 1'b1;
      end
      `RSS_OP_SKIP_BIT:
        skip = |(opnd & bit_mask);
      `RSS_OP_SKIP_NZ:
      begin
        res    = opnd;
        wr_mem = 1'b1;
        skip   = (opnd != `RSS_BYTE_ZERO);
      end
      default:
        res = opnd;
    endcase
    // Six flags of the subtract forms; chained zero accumulates only with borrow
    if (sub_flags)
    begin
      flg[`RSS_F_C]    = ~diff[8];
      flg[`RSS_F_HALF] = ~lo_diff[4];
      flg[`RSS_F_Z]    = (sres == `RSS_BYTE_ZERO);
      flg[`RSS_F_WRAP] = s_ov;
      flg[`RSS_F_SCMP] = ~(sres[7] ^ s_ov);
      flg[`RSS_F_CHZ]  = is_sub ? (sres == `RSS_BYTE_ZERO)
                                : ((sres == `RSS_BYTE_ZERO) & flags_q[`RSS_F_CHZ]);
    end
  end

  // --------------------------------------------------------------------------
  // Result, skip and dummy registers
  // --------------------------------------------------------------------------
  // Skip leaves with the result at the same edge so the fetched word is squashed
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_we_q    <= 1'b0;
      mem_addr_q  <= `RSS_BYTE_ZERO;
      mem_wdata_q <= `RSS_BYTE_ZERO;
      skip_q      <= 1'b0;
      dummy_q     <= 1'b0;
      done_q      <= 1'b0;
      last_skip_q <= 1'b0;
    end
    else
    begin
      mem_we_q <= go & wr_mem;
      skip_q   <= go & skip;
      dummy_q  <= go & skip;
      done_q   <= go;
      if (go)
      begin
        mem_addr_q  <= maddr;
        mem_wdata_q <= res;
        last_skip_q <= skip;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Accumulator and flags; execution wins over a bus write in the same cycle
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_q   <= `RSS_BYTE_ZERO;
      flags_q <= `RSS_FLAG_RST;
    end
    else
    begin
      if (go & wr_acc)
        acc_q <= res;
      else if (wr_pend_q & (bus_addr_q == `RSS_REG_ACC))
        acc_q <= hwdata[7:0];
      if (go)
        flags_q <= flg;
      else if (wr_pend_q & (bus_addr_q == `RSS_REG_STATUS))
        flags_q <= hwdata[`RSS_FLAG_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Software command registers
  // --------------------------------------------------------------------------
  // A new command write while one is pending replaces it; software should poll busy
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opnd_reg_q <= `RSS_BYTE_ZERO;
      cmd_op_q   <= 5'h00;
      cmd_bit_q  <= 3'h0;
      cmd_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_pend_q & (bus_addr_q == `RSS_REG_OPND))
        opnd_reg_q <= hwdata[7:0];
      if (sw_cmd_wr)
      begin
        cmd_op_q   <= hwdata[`RSS_CMD_OP_LSB +: `RSS_OP_W];
        cmd_bit_q  <= hwdata[`RSS_CMD_BIT_LSB +: 3];
        cmd_pend_q <= 1'b1;
      end
      else if (go & ~exec_valid)
        cmd_pend_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave: writes zero wait, reads one wait state
  // --------------------------------------------------------------------------
  // The read wait state keeps a read right after a write from seeing stale data
  always @*
  begin
    rd_mux = `RSS_WORD_ZERO;
    case (bus_addr_q)
      `RSS_REG_ACC:    rd_mux[7:0] = acc_q;
      `RSS_REG_STATUS: rd_mux[`RSS_FLAG_W-1:0] = flags_q;
      `RSS_REG_OPND:   rd_mux[7:0] = opnd_reg_q;
      `RSS_REG_CMD:
      begin
        rd_mux[`RSS_CMD_OP_LSB +: `RSS_OP_W] = cmd_op_q;
        rd_mux[`RSS_CMD_BIT_LSB +: 3]        = cmd_bit_q;
      end
      `RSS_REG_LAST:
      begin
        rd_mux[7:0]                = mem_wdata_q;
        rd_mux[`RSS_LAST_WE_BIT]   = mem_we_q;
        rd_mux[`RSS_LAST_SKIP_BIT] = last_skip_q;
        rd_mux[`RSS_LAST_BUSY_BIT] = cmd_pend_q;
      end
      default:         rd_mux = `RSS_WORD_ZERO;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q  <= 1'b0;
      rd_pend_q  <= 1'b0;
      bus_addr_q <= 5'h00;
      hreadyout  <= 1'b1;
      hrdata     <= `RSS_WORD_ZERO;
      hresp      <= 1'b0;
    end
    else
    begin
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      if (rd_pend_q)
      begin
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
      end
      else if (hsel & hready & (htrans == `RSS_HTRANS_NONSEQ))
      begin
        // Unmapped addresses decode to a slot that reads zero and ignores writes
        bus_addr_q <= addr_ok ? {haddr[`RSS_ADDR_W-1:2], 2'b00} : `RSS_REG_NONE;
        wr_pend_q  <= hwrite;
        rd_pend_q  <= ~hwrite;
        hreadyout  <= hwrite;
      end
    end
  end

endmodule // rss_exec

// ==== include/rss_consts.vh ====
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define RSS_OP_W            5
`define RSS_OP_ROTL_C_ACC   5'h00
`define RSS_OP_ROTR         5'h01
`define RSS_OP_ROTR_ACC     5'h02
`define RSS_OP_ROTR_C       5'h03
`define RSS_OP_ROTR_C_ACC   5'h04
`define RSS_OP_SUBB         5'h05
`define RSS_OP_SUBB_IMM     5'h06
`define RSS_OP_SUBB_MEM     5'h07
`define RSS_OP_SUB          5'h08
`define RSS_OP_DEC_SKIP     5'h09
`define RSS_OP_DEC_ACC_SKIP 5'h0a
`define RSS_OP_INC_SKIP     5'h0b
`define RSS_OP_INC_ACC_SKIP 5'h0c
`define RSS_OP_SET          5'h0d
`define RSS_OP_SET_BIT      5'h0e
`define RSS_OP_SKIP_BIT     5'h0f
`define RSS_OP_SKIP_NZ      5'h10

// ----------------------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------------------
`define RSS_FLAG_W          6
`define RSS_F_C             0
`define RSS_F_HALF          1
`define RSS_F_Z             2
`define RSS_F_WRAP          3
`define RSS_F_SCMP          4
`define RSS_F_CHZ           5

// ----------------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define RSS_ADDR_W          5
`define RSS_REG_ACC         5'h00
`define RSS_REG_STATUS      5'h04
`define RSS_REG_OPND        5'h08
`define RSS_REG_CMD         5'h0c
`define RSS_REG_LAST        5'h10
`define RSS_REG_NONE        5'h1c
`define RSS_CMD_OP_LSB      0
`define RSS_CMD_BIT_LSB     8
`define RSS_LAST_WE_BIT     8
`define RSS_LAST_SKIP_BIT   9
`define RSS_LAST_BUSY_BIT   10

// ----------------------------------------------------------------------------
// Constants
// ----------------------------------------------------------------------------
`define RSS_HTRANS_NONSEQ   2'h2
`define RSS_BYTE_ZERO       8'h00
`define RSS_BYTE_ONE        8'h01
`define RSS_BYTE_ALL        8'hff
`define RSS_NIB_ZERO        4'h0
`define RSS_WORD_ZERO       32'h0000_0000
`define RSS_FLAG_RST        6'h00

`endif

// ==== verif/rss_exec_chk.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Checker on the execution port
// ----------------------------------------------------------------------------
module rss_exec_chk
(
  // Clock and reset
  input wire       hclk,
  input wire       hresetn,
  // Decoder request
  input wire       exec_valid,
  input wire [4:0] exec_op,
  input wire [2:0] exec_bit,
  input wire [7:0] exec_operand,
  // Results
  input wire       mem_we_q,
  input wire [7:0] mem_wdata_q,
  input wire       skip_q,
  input wire       dummy_q,
  input wire       done_q,
  input wire [7:0] acc_q,
  input wire [5:0] flags_q
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // An instruction is only taken outside the dummy cycle
  wire tk = exec_valid && !dummy_q;

  a_skip_dummy: assert property (skip_q == dummy_q) else $error("skip without dummy");
  a_dummy_once: assert property (dummy_q |=> !dummy_q && !done_q) else $error("dummy not single");
  a_skip_done: assert property (skip_q |-> done_q) else $error("skip apart from result");
  a_rotl_acc: assert property (tk && exec_op == 5'h00 |=> acc_q == {$past(exec_operand[6:0]), $past(flags_q[0])}
    && flags_q[0] == $past(exec_operand[7]) && !mem_we_q) else $error("left rotate wrong");
  a_rotr_mem: assert property (tk && exec_op == 5'h01 |=> mem_we_q && $stable(flags_q)
    && mem_wdata_q == {$past(exec_operand[0]), $past(exec_operand[7:1])}) else $error("right rotate wrong");
  a_dec_skip: assert property (tk && exec_op == 5'h09 |=> mem_we_q
    && skip_q == ($past(exec_operand) == 8'h01)) else $error("decrement skip wrong");
  a_inc_acc: assert property (tk && exec_op == 5'h0c |=> !mem_we_q
    && acc_q == $past(exec_operand) + 8'h01) else $error("increment acc wrong");
  a_set_byte: assert property (tk && exec_op == 5'h0d |=> mem_we_q && mem_wdata_q == 8'hff)
    else $error("set byte wrong");
  a_set_bit: assert property (tk && exec_op == 5'h0e |=> mem_we_q
    && mem_wdata_q == ($past(exec_operand) | (8'h01 << $past(exec_bit)))) else $error("set bit wrong");
  a_bit_skip: assert property (tk && exec_op == 5'h0f |=> skip_q == $past(exec_operand[exec_bit])
    && !mem_we_q) else $error("bit skip wrong");
endmodule // rss_exec_chk

bind rss_exec rss_exec_chk u_chk (.hclk, .hresetn, .exec_valid, .exec_op, .exec_bit, .exec_operand,
  .mem_we_q, .mem_wdata_q, .skip_q, .dummy_q, .done_q, .acc_q, .flags_q);

// ==== verif/rss_exec_test.sv ====
`timescale 1ns/1ps

module rss_exec_test;
  logic        hclk, hresetn, hsel, hwrite, exec_valid, sq;
  logic [31:0] haddr, hwdata, r;
  logic [1:0]  htrans;
  logic [4:0]  exec_op;
  logic [2:0]  exec_bit;
  logic [7:0]  exec_operand, exec_addr, ma;
  logic [5:0]  mf;
  wire         hreadyout, hresp, mem_we_q, skip_q, dummy_q, done_q;
  wire  [31:0] hrdata;
  wire  [7:0]  mem_addr_q, mem_wdata_q, acc_q;
  wire  [5:0]  flags_q;
  logic [31:0] q[$];
  int          n_fail, comparisons;

  rss_exec uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .exec_valid, .exec_op, .exec_bit,
    .exec_operand, .exec_addr, .mem_we_q, .mem_addr_q, .mem_wdata_q, .skip_q, .dummy_q,
    .done_q, .acc_q, .flags_q);

  // Clock at 50 MHz
  always #10 hclk = ~hclk;

  // ----------------------------------------------------------------------------
  // Shared checks and closing
  // ----------------------------------------------------------------------------
  task automatic chk(input [31:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Waits for an edge with hready high; a stuck slave ends the run
  task automatic rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      n_fail++;
      conclude();
    end
  endtask

  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input [31:0] a, d, input w);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // ----------------------------------------------------------------------------
  // Reference model: notes the expected result of one taken instruction
  // ----------------------------------------------------------------------------
  task automatic model(input [4:0] o, input [2:0] b, input [7:0] x, a);
    logic we, sk, bi, ov;
    logic [7:0] w, t;
    logic [8:0] d;
    logic [4:0] h;
    we = 0;
    sk = 0;
    w = 8'h00;
    case (o)
      0: {ma, mf[0]} = {x[6:0], mf[0], x[7]};
      1: {we, w} = {1'b1, x[0], x[7:1]};
      2: ma = {x[0], x[7:1]};
      3: {we, w, mf[0]} = {1'b1, mf[0], x[7:1], x[0]};
      4: {ma, mf[0]} = {mf[0], x[7:1], x[0]};
      5, 6, 7, 8:
      begin
        bi = (o == 8) ? 1'b0 : ~mf[0];
        d = {1'b0, ma} - {1'b0, x} - {8'h00, bi};
        h = {1'b0, ma[3:0]} - {1'b0, x[3:0]} - {4'h0, bi};
        t = d[7:0];
        ov = (ma[7] ^ x[7]) & (t[7] ^ ma[7]);
        mf = {(t == 0) & (o == 8 | mf[5]), ~(t[7] ^ ov), ov, t == 0, ~h[4], ~d[8]};
        if (o == 7) {we, w} = {1'b1, t};
        else ma = t;
      end
      9: begin we = 1; w = x - 8'h01; sk = w == 0; end
      10: begin ma = x - 8'h01; sk = ma == 0; end
      11: begin we = 1; w = x + 8'h01; sk = w == 0; end
      12: begin ma = x + 8'h01; sk = ma == 0; end
      13: {we, w} = {1'b1, 8'hff};
      14: {we, w} = {1'b1, x | (8'h01 << b)};
      15: sk = x[b];
      16: {we, w, sk} = {1'b1, x, x != 0};
      default: sk = 0; // Unused codes write nothing and never skip
    endcase
    sq = sk;
    q.push_back({a, we, w, sk, ma, mf});
  endtask

  // Issues one instruction; the one after a skip is dropped by the block
  task automatic ex(input [4:0] o, input [2:0] b, input [7:0] x, a);
    exec_valid <= 1;
    exec_op <= o;
    exec_bit <= b;
    exec_operand <= x;
    exec_addr <= a;
    if (sq) sq = 0;
    else model(o, b, x, a);
    @(posedge hclk);
  endtask

  // Takes the oldest note off the queue at each result pulse
  always @(negedge hclk)
    if (hresetn && done_q === 1'b1)
    begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else chk({mem_addr_q, mem_we_q, mem_we_q ? mem_wdata_q : 8'h00, skip_q, acc_q, flags_q}, q.pop_front());
    end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    int i;
    {hclk, hresetn, hsel, hwrite, exec_valid, sq, htrans, exec_op, exec_bit} = 0;
    {haddr, hwdata, exec_operand, exec_addr, ma, mf} = 0;
    void'($urandom(93));
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    // Registers, a software command and an unmapped read
    bus(32'h00, 0, 0);
    chk(r, 0);
    bus(32'h00, 32'h35, 1);
    bus(32'h04, 32'h01, 1);
    bus(32'h08, 32'h40, 1);
    {ma, mf} = {8'h35, 6'h01};
    model(8, 0, 8'h40, 0);
    bus(32'h0c, 32'h08, 1);
    bus(32'h00, 0, 0);
    chk(r, {24'h0, ma});
    bus(32'h04, 0, 0);
    chk(r, {26'h0, mf});
    bus(32'h10, 0, 0);
    chk(r, {24'h0, ma});
    bus(32'h0c, 0, 0);
    chk(r, 32'h08);
    bus(32'h40, 0, 0);
    chk(r, 0);
    hsel <= 0;
    $display("bus test done");
    // Every operation, boundary operands, squashed followers
    ex(9, 0, 8'h01, 8'h11);
    ex(0, 0, 8'h80, 8'h12);
    ex(11, 0, 8'hff, 8'h13);
    ex(12, 0, 8'hff, 8'h14);
    ex(10, 0, 8'h01, 8'h15);
    ex(1, 0, 8'h22, 8'h16);
    for (i = 0; i < 17; i++) ex(i[4:0], i[2:0], 8'h81 + i[7:0], i[7:0]);
    ex(12, 0, 8'h7f, 8'h20);
    ex(16, 0, 8'h00, 8'h21);
    ex(15, 7, 8'h7f, 8'h22);
    ex(5, 0, 8'h00, 8'h23);
    ex(6, 0, 8'h80, 8'h24);
    ex(7, 0, 8'h01, 8'h25);
    ex(17, 0, 8'h5a, 8'h26);
    $display("directed test done");
    // Random back to back stream
    repeat (400)
    begin
      r = $urandom;
      ex(r[4:0] % 5'd17, r[7:5], r[15:8], r[23:16]);
    end
    exec_valid <= 0;
    i = 0;
    while (q.size() > 0 && i < 50)
    begin
      @(posedge hclk);
      i++;
    end
    if (q.size() > 0) n_fail++;
    $display("random test done");
    conclude();
  end
endmodule // rss_exec_test
